//--- design/ddp_bank.sv
// drive diagnosis parameter bank: jog, forcing, input merge, status, trims
// assumes synchronous pins, one clock at 40 MHz, host on the register port
`timescale 1ns/1ps
module ddp_bank #(
    parameter logic [15:0] TRIM_PRI_FACTORY = 16'h4000,
    parameter logic [15:0] TRIM_AUX_FACTORY = 16'h4000
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // register port
    input  wire ddp_pkg::ddp_req_type req,
    output logic [15:0]            rdata,
    // pins
    input  wire logic [8:0]        input_terminal,
    input  wire logic [4:0]        panel_keys,
    input  wire logic [5:0]        drive_outputs,
    output logic [5:0]             output_contacts,
    output logic [8:0]             input_combined,
    // motion and calibration
    output logic [15:0]            jog_speed,
    output ddp_pkg::ddp_jog_type   jog_state,
    output ddp_pkg::ddp_cal_type   cal_req,
    output logic [15:0]            trim_primary,
    output logic [15:0]            trim_auxiliary
);
    import ddp_pkg::*;

    logic [15:0] jog_q, force_q, sdi_q, mask_q, special_q, cal_q, tpri_q, taux_q, rdata_q;
    logic [8:0]  comb_q;
    logic [5:0]  outc_q;
    ddp_jog_type jst_q;
    ddp_cal_type calr_q;
    logic        tpri_load_q;

    // address decode
    wire wr = req.wr;
    wire [15:0] wd = req.wdata;
    wire wr_jog   = wr && req.addr == ADDR_JOG && wd <= JOG_MAX;            // R1 R16
    wire wr_force = wr && req.addr == ADDR_FORCE && wd <= FORCE_MAX;        // R3 R16
    wire wr_sdi   = wr && req.addr == ADDR_INSTAT && wd <= INSTAT_MAX;      // R7 R16
    wire wr_mask  = wr && req.addr == ADDR_SRCMASK && wd <= INSTAT_MAX;
    wire wr_spec  = wr && req.addr == ADDR_SPECIAL;
    wire adj_en   = (special_q & ADJ_ENABLE) != 16'h0000;
    wire wr_cal   = wr && req.addr == ADDR_CAL && wd <= CAL_MAX && adj_en;  // R10 R11 R16
    wire wr_tpri  = wr && req.addr == ADDR_TRIM_PRI && wd <= TRIM_MAX && adj_en; // R11 R13
    wire wr_taux  = wr && req.addr == ADDR_TRIM_AUX && wd <= TRIM_MAX && adj_en; // R11 R13
    wire wr_dflt  = wr && req.addr == ADDR_DEFAULTS && wd == DEFAULTS_KEY;

    // combined inputs: software bit where mask is set, terminal otherwise
    wire [8:0] comb_d = (mask_q[8:0] & sdi_q[8:0]) | (~mask_q[8:0] & input_terminal); // R5

    // forcing overrides drive outputs only while the force word is nonzero
    wire [5:0] outc_d = (force_q != 16'h0000) ? force_q[5:0] : drive_outputs; // R3 R4

    // jog decode: the two magic codes are direction commands, not speeds
    wire         jog_dir = wd == JOG_POS_CODE || wd == JOG_NEG_CODE;
    ddp_jog_type jst_d;
    assign jst_d = !wr_jog ? jst_q :
                   (wd == 16'h0000) ? DDP_JOG_STOP :
                   (wd == JOG_POS_CODE) ? DDP_JOG_POS :
                   (wd == JOG_NEG_CODE) ? DDP_JOG_NEG : jst_q; // R1

    // read mux: unmapped addresses read zero
    logic [15:0] rmux;
    always_comb begin
        unique case (req.addr)
            ADDR_JOG:      rmux = jog_q;
            ADDR_FORCE:    rmux = force_q;
            ADDR_INSTAT:   rmux = {7'h00, comb_q};             // R6
            ADDR_KEYS:     rmux = {11'h000, panel_keys};       // R8
            ADDR_OUTSTAT:  rmux = {10'h000, outc_q};           // R9
            ADDR_CAL:      rmux = cal_q;
            ADDR_TRIM_PRI: rmux = tpri_q;
            ADDR_TRIM_AUX: rmux = taux_q;
            ADDR_SRCMASK:  rmux = mask_q;
            ADDR_SPECIAL:  rmux = special_q;
            default:       rmux = 16'h0000;
        endcase
    end

    // control registers; the defaults write restores them but not the trims
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            jog_q     <= JOG_RESET;
            force_q   <= 16'h0000;
            sdi_q     <= 16'h0000;
            mask_q    <= 16'h0000;
            special_q <= 16'h0000;
            cal_q     <= 16'h0000;
        end else if (wr_dflt) begin
            jog_q     <= JOG_RESET;
            force_q   <= 16'h0000;
            sdi_q     <= 16'h0000;
            mask_q    <= 16'h0000;
            special_q <= 16'h0000;
            cal_q     <= 16'h0000;
        end else begin
            if (wr_jog && !jog_dir && wd != 16'h0000) jog_q <= wd; // R1
            if (wr_force) force_q <= wd;                 // R3 R4
            if (wr_sdi) sdi_q <= wd;                     // R7
            if (wr_mask) mask_q <= wd;
            if (wr_spec) special_q <= wd;
            if (wr_cal) cal_q <= wd;                     // R10
        end
    end

    // trims: factory values at power-up, untouched by the defaults write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tpri_q <= 16'h0000;
            taux_q <= 16'h0000;
            tpri_load_q <= 1'b1;
        end else if (tpri_load_q) begin
            tpri_q <= TRIM_PRI_FACTORY;                  // R13
            taux_q <= TRIM_AUX_FACTORY;
            tpri_load_q <= 1'b0;
        end else begin
            if (wr_tpri) tpri_q <= wd;                   // R13 R14
            if (wr_taux) taux_q <= wd;                   // R13 R14
        end
    end

    // status, outputs and calibration pulse; every output is a flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            comb_q  <= 9'h000;
            outc_q  <= 6'h00;
            jst_q   <= DDP_JOG_STOP;
            calr_q  <= '0;
            rdata_q <= 16'h0000;
        end else begin
            comb_q  <= comb_d;
            outc_q  <= outc_d;
            jst_q   <= wr_dflt ? DDP_JOG_STOP : jst_d;
            calr_q  <= '{strobe: wr_cal && wd != 16'h0000, sel: wd[2:0]}; // R10 R11
            rdata_q <= req.rd ? rmux : 16'h0000;
        end
    end

    assign rdata = rdata_q;
    assign output_contacts = outc_q;
    assign input_combined = comb_q;
    assign jog_speed = jog_q;
    assign jog_state = jst_q;
    assign cal_req = calr_q;
    assign trim_primary = tpri_q;
    assign trim_auxiliary = taux_q;
endmodule : ddp_bank

//--- design/ddp_pkg.sv
// constants, layouts and types of the drive diagnosis parameter bank
// assumes a plain register port with one-cycle strobes and 16-bit data
// Function
// R1: jog word takes 1..5000 as speed; 4998 jog plus, 4999 jog minus, 0 stops
// R2: host should set the auxiliary function parameter to 5 for frequent jog writes
// R3: forced-output register is 16 bits, range 0..0x3F, forces output contacts, resets zero
// R4: writing zero to forced-output cancels forcing, outputs return to normal
// R5: each of nine inputs comes from software bit if mask bit 1, else terminal
// R6: input status read returns combined inputs, bit n is input n+1
// R7: input status write sets nine software input bits, terminals unaffected
// R8: read-only key status word reports the five front-panel keys
// R9: output status word is read-only, 0..0x3F, same value for panel and link
// R10: calibration command accepts 0..6 selecting the offset calibrations
// R11: calibration and manual offset writes only when special function enables adjustment
// R12: host ensures analog wiring removed and drive disabled before calibration
// R13: speed offset trims hold 0..32767, start at factory values, manually adjustable
// R14: offset trims keep their values through a parameter reset to defaults
// R15: host is advised not to modify the auxiliary offset trim
// R16: out-of-range writes are ignored and the register keeps its contents
package ddp_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int NUM_IN = 9;
    localparam int NUM_OUT = 6;
    localparam int NUM_KEY = 5;

    // register addresses
    localparam logic [11:0] ADDR_JOG      = 12'h40A;
    localparam logic [11:0] ADDR_FORCE    = 12'h40C;
    localparam logic [11:0] ADDR_INSTAT   = 12'h40E;
    localparam logic [11:0] ADDR_KEYS     = 12'h410;
    localparam logic [11:0] ADDR_OUTSTAT  = 12'h412;
    localparam logic [11:0] ADDR_CAL      = 12'h414;
    localparam logic [11:0] ADDR_TRIM_PRI = 12'h416;
    localparam logic [11:0] ADDR_TRIM_AUX = 12'h418;
    localparam logic [11:0] ADDR_SRCMASK  = 12'h306;
    localparam logic [11:0] ADDR_SPECIAL  = 12'h210;
    localparam logic [11:0] ADDR_DEFAULTS = 12'h420;

    // ranges and codes
    localparam logic [15:0] JOG_MAX       = 16'h1388; // 5000
    localparam logic [15:0] JOG_POS_CODE  = 16'h1386; // 4998
    localparam logic [15:0] JOG_NEG_CODE  = 16'h1387; // 4999
    localparam logic [15:0] JOG_RESET     = 16'h0014; // 20
    localparam logic [15:0] FORCE_MAX     = 16'h003F;
    localparam logic [15:0] INSTAT_MAX    = 16'h01FF;
    localparam logic [15:0] CAL_MAX       = 16'h0006;
    localparam logic [15:0] CAL_ALL       = 16'h0005;
    localparam logic [15:0] TRIM_MAX      = 16'h7FFF;
    localparam logic [15:0] ADJ_ENABLE    = 16'h0001; // special function bit that enables adjustment
    localparam logic [15:0] DEFAULTS_KEY  = 16'h0001;

    typedef enum logic [2:0] {
        DDP_JOG_STOP = 3'b001,
        DDP_JOG_POS  = 3'b010,
        DDP_JOG_NEG  = 3'b100
    } ddp_jog_type;

    // one bus request
    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ddp_req_type;

    // calibration request towards the analog front end
    typedef struct packed {
        logic       strobe;
        logic [2:0] sel;
    } ddp_cal_type;
endpackage : ddp_pkg

//--- verification/ddp_chk_assertions.sv
// port relations of the diagnosis bank
// assumes bind onto ddp_bank, one clock, async low reset
`timescale 1ns/1ps
module ddp_chk (
    // clock, reset, register port
    input wire logic                 clk,
    input wire logic                 arst_n,
    input wire ddp_pkg::ddp_req_type req,
    input wire logic [15:0]          rdata,
    // watched pins and outputs
    input wire logic [8:0]           input_combined,
    input wire logic [5:0]           drive_outputs,
    input wire logic [5:0]           output_contacts,
    input wire logic [15:0]          jog_speed,
    input wire ddp_pkg::ddp_jog_type jog_state,
    input wire ddp_pkg::ddp_cal_type cal_req,
    input wire logic [15:0]          trim_primary
);
    import ddp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // write decodes shared by the properties
    wire wf = req.wr && req.addr == ADDR_FORCE;
    wire wj = req.wr && req.addr == ADDR_JOG;
    a_force_drive: assert property (wf && req.wdata inside {[16'h0001:FORCE_MAX]} ##1 !wf
        |-> ##1 output_contacts == $past(req.wdata[5:0], 2)) else $error("force lost");
    a_force_cancel: assert property (wf && req.wdata == 16'h0000 ##1 !wf
        |-> ##1 output_contacts == $past(drive_outputs)) else $error("force kept");
    a_instat_read: assert property (req.rd && req.addr == ADDR_INSTAT
        |=> rdata == {7'h00, $past(input_combined)}) else $error("input status");
    a_outstat_read: assert property (req.rd && req.addr == ADDR_OUTSTAT
        |=> rdata == {10'h000, $past(output_contacts)}) else $error("output status");
    a_jog_speed: assert property (wj && req.wdata inside {[16'h0001:JOG_MAX]}
        && req.wdata != JOG_POS_CODE && req.wdata != JOG_NEG_CODE
        |=> jog_speed == $past(req.wdata)) else $error("jog speed");
    a_jog_dir: assert property (wj && req.wdata == JOG_POS_CODE
        |=> jog_state == DDP_JOG_POS && $stable(jog_speed)) else $error("jog dir");
    a_jog_refuse: assert property (wj && req.wdata > JOG_MAX
        |=> $stable(jog_speed) && $stable(jog_state)) else $error("jog refuse");
    a_cal_cause: assert property (cal_req.strobe
        |-> $past(req.wr && req.addr == ADDR_CAL && req.wdata inside {[16'h0001:CAL_MAX]})
        && cal_req.sel == $past(req.wdata[2:0])) else $error("cal strobe");
    // the factory load one edge after reset is the only change not caused by a write
    a_trim_cause: assert property ($changed(trim_primary) && $past(arst_n, 2)
        |-> $past(req.wr && req.addr == ADDR_TRIM_PRI)) else $error("trim change");
endmodule : ddp_chk
bind ddp_bank ddp_chk u_chk (.clk, .arst_n, .req, .rdata, .input_combined, .drive_outputs,
    .output_contacts, .jog_speed, .jog_state, .cal_req, .trim_primary);

//--- verification/ddp_host.sv
// host on the register port: one strobe cycle, then one idle cycle
// assumes the bank takes requests on the rising edge
`timescale 1ns/1ps
module ddp_host (
    // clock and register port
    input  wire logic           clk,
    output ddp_pkg::ddp_req_type req
);
    import ddp_pkg::*;
    initial req = '0;
    // callers keep the drive disabled and unwired before calibration
    // callers leave the auxiliary trim alone and set aux function 5 for jog bursts
    task automatic access(input logic [11:0] a, input logic [15:0] d, input logic w);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : access
endmodule : ddp_host

//--- verification/drive_diagnosis_params_tb.sv
// bench of the diagnosis bank: reads queued, compared when data appear
// assumes ddp_host drives the port and the checker is bound
`timescale 1ns/1ps
module drive_diagnosis_params_tb;
    import ddp_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, rd_q = 1'b0;
    ddp_req_type req;
    ddp_jog_type jog_state;
    ddp_cal_type cal_req;
    logic [15:0] rdata, jog_speed, trim_primary, trim_auxiliary, r, exp_q[$];
    logic [15:0] seed = 16'h0006;
    logic [8:0]  input_terminal, input_combined;
    logic [5:0]  drive_outputs, output_contacts;
    logic [4:0]  panel_keys;
    int          n_mismatch = 0, comparisons = 0, n_strobe = 0;
    logic [15:0] jog_w[5] = '{16'h0064, JOG_POS_CODE, JOG_NEG_CODE, 16'h0000, 16'h1389};
    ddp_jog_type jog_e[5] = '{DDP_JOG_STOP, DDP_JOG_POS, DDP_JOG_NEG, DDP_JOG_STOP, DDP_JOG_STOP};
    always #12.5 clk = ~clk;
    ddp_host u_host (.clk, .req);
    ddp_bank #(.TRIM_PRI_FACTORY(16'h4000), .TRIM_AUX_FACTORY(16'h2000)) u_dut (.clk, .arst_n,
        .req, .rdata, .input_terminal, .panel_keys, .drive_outputs, .output_contacts,
        .input_combined, .jog_speed, .jog_state, .cal_req, .trim_primary, .trim_auxiliary);
    function automatic logic [15:0] xs();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction : xs
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        u_host.access(a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        u_host.access(a, 16'h0000, 1'b0);
    endtask : rd
    task automatic end_of_test();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    // read data stand only in the cycle after the strobe, so compare there
    always @(posedge clk) begin
        if (rd_q)
            cmp(rdata, exp_q.pop_front());
        rd_q <= req.rd;
        n_strobe <= n_strobe + int'(cal_req.strobe === 1'b1);
    end
    // a hang counts as a mismatch
    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {input_terminal, panel_keys, drive_outputs} = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        r = xs();
        {drive_outputs, input_terminal} <= r[14:0];
        r = xs();
        panel_keys <= r[15:11];
        cmp(trim_primary, 16'h4000);
        rd(ADDR_FORCE, 16'h0000);
        rd(ADDR_CAL, 16'h0000);
        rd(12'h7FE, 16'h0000);
        rd(ADDR_KEYS, {11'h000, r[15:11]});
        wr(ADDR_FORCE, 16'h002A);
        wr(ADDR_FORCE, 16'h0040);
        rd(ADDR_OUTSTAT, 16'h002A);
        wr(ADDR_FORCE, 16'h0000);
        rd(ADDR_OUTSTAT, {10'h000, drive_outputs});
        wr(ADDR_SRCMASK, 16'h00F0);
        wr(ADDR_INSTAT, 16'h01A5);
        wr(ADDR_INSTAT, 16'h0200);
        rd(ADDR_INSTAT, {7'h00, 9'h0A0 | (input_terminal & 9'h10F)});
        cmp({7'h00, input_combined}, {7'h00, 9'h0A0 | (input_terminal & 9'h10F)});
        foreach (jog_w[i]) begin
            wr(ADDR_JOG, jog_w[i]);
            cmp({13'h0000, jog_state}, {13'h0000, jog_e[i]});
            cmp(jog_speed, 16'h0064);
        end
        wr(ADDR_CAL, 16'h0001);
        wr(ADDR_TRIM_PRI, 16'h1234);
        cmp(trim_primary, 16'h4000);
        wr(ADDR_SPECIAL, ADJ_ENABLE);
        for (int c = 0; c <= 7; c++)
            wr(ADDR_CAL, 16'(c));
        cmp(16'(n_strobe), 16'h0006);
        rd(ADDR_CAL, CAL_MAX);
        wr(ADDR_TRIM_PRI, TRIM_MAX);
        wr(ADDR_TRIM_PRI, 16'h8000);
        wr(ADDR_DEFAULTS, DEFAULTS_KEY);
        cmp(trim_primary, TRIM_MAX);
        cmp(trim_auxiliary, 16'h2000);
        end_of_test();
    end
endmodule : drive_diagnosis_params_tb
